// [hdl/nicr_pkg.sv]
// package for the network identifier clash and realignment control block
// shared by the top module and its parameter store; no clock assumptions
package nicr_pkg;

    // field widths
    localparam int ID_W    = 16;
    localparam int SADDR_W = 16;
    localparam int LADDR_W = 64;
    localparam int CHAN_W  = 3;
    localparam int EXP_W   = 4;
    localparam int SEC_W   = 8;

    // exponent that selects nonbeacon operation
    localparam logic [EXP_W-1:0] EXP_NONBEACON = 4'hf;

    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_NET_ID  = 8'h04;
    localparam logic [7:0] OFS_PSHORT  = 8'h08;
    localparam logic [7:0] OFS_PLONG_L = 8'h0c;
    localparam logic [7:0] OFS_PLONG_H = 8'h10;
    localparam logic [7:0] OFS_REQ     = 8'h14;
    localparam logic [7:0] OFS_CUR     = 8'h18;
    localparam logic [7:0] OFS_STATUS  = 8'h1c;
    localparam logic [7:0] OFS_MASK    = 8'h20;
    localparam logic [7:0] OFS_NOTICE  = 8'h24;

    // control register fields
    localparam int CTRL_IS_ROOT   = 0;
    localparam int CTRL_JOINED    = 1;
    localparam int CTRL_CLASH_EN  = 2;
    localparam int CTRL_BEACONING = 3;

    // request register fields: [15:0] id, [18:16] channel, [23:20] bi exp, [27:24] ap exp
    localparam int REQ_CHAN_LSB = 16;
    localparam int REQ_BI_LSB   = 20;
    localparam int REQ_AP_LSB   = 24;
    localparam int REQ_GO       = 31;

    // status bits (sticky, write one to clear)
    localparam int ST_NOTICE   = 0;
    localparam int ST_CNF_OK   = 1;
    localparam int ST_CNF_BUSY = 2;
    localparam int ST_REFUSED  = 3;
    localparam int ST_W        = 4;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0004;
    localparam logic [31:0] CUR_RST  = 32'h0ff0_0000;

    // loss causes and confirm statuses
    typedef enum logic [1:0] {
        CAUSE_NONE    = 2'b00,
        CAUSE_CLASH   = 2'b01,
        CAUSE_REALIGN = 2'b10
    } nicr_cause_e;

    typedef enum logic [1:0] {
        CNF_NONE    = 2'b00,
        CNF_SUCCESS = 2'b01,
        CNF_BUSY    = 2'b10
    } nicr_cnf_e;

endpackage

// [hdl/nicr_param_store.sv]
// parameter store: current network id, channel and superframe exponents
// assumes the caller pulses apply for one cycle with the pending values valid
`timescale 1ns/1ns
`default_nettype none
module nicr_param_store
    import nicr_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // load from register bank and apply from realignment
    input  wire logic             load,
    input  wire logic [ID_W-1:0]  load_id,
    input  wire logic             apply,
    input  wire logic [ID_W-1:0]  new_id,
    input  wire logic [CHAN_W-1:0] new_chan,
    input  wire logic [EXP_W-1:0] new_bi,
    input  wire logic [EXP_W-1:0] new_ap,
    // current values
    output logic      [ID_W-1:0]  cur_id,
    output logic      [31:0]      cur_word
);
    typedef struct packed {
        logic [ID_W-1:0]  id;
        logic [31:0]      word;
    } nicr_ps_s;

    nicr_ps_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.id = load_id;
        end
        if (apply) begin
            st_d.id = new_id;
            st_d.word = '0;
            st_d.word[REQ_CHAN_LSB +: CHAN_W] = new_chan;
            st_d.word[REQ_BI_LSB +: EXP_W] = new_bi;
            // nonbeacon interval forces nonbeacon active period
            st_d.word[REQ_AP_LSB +: EXP_W] = (new_bi == EXP_NONBEACON) ?
                                             EXP_NONBEACON : new_ap;
        end
        st_d.word[ID_W-1:0] = st_d.id;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{id: '0, word: CUR_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign cur_id   = st_q.id;
    assign cur_word = st_q.word;
endmodule
`default_nettype wire

// [hdl/nicr_top.sv]
// network identifier clash detection and coordinator realignment control
// apb slave for software; frame-level strobes from the mac receive and
// transmit engines on the same clock
//
// Behaviour
// - root flags clash on coordinator beacon carrying its own network id
// - root flags clash on conflict notification from an associated device
// - root-joined device flags clash on foreign coordinator beacon with our id
// - device sends conflict notification with ack request after a clash
// - device raises clash notice only after that acknowledgment
// - no acknowledgment means no clash notice upward
// - coordinator raises clash notice directly, no ack needed
// - realign request sends command with new id and channel
// - if beaconing, next beacon on current settings with frame pending
// - realign command follows that beacon, unslotted random access
// - if not beaconing, command sent at once, unslotted access
// - access failure gives confirm with medium busy status
// - success applies new parameters at next beacon or at once, confirm success
// - realign command from own coordinator raises realign notice with its fields
// - clash procedure can be switched off in a device
// - beacon exponent fifteen forces active period exponent fifteen
// - sync loss notice stops own beacon transmission
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module nicr_top
    import nicr_pkg::*;
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // received frames, one-cycle strobes
    input  wire logic               rx_beacon,
    input  wire logic               rx_coord_bit,
    input  wire logic [ID_W-1:0]    rx_net_id,
    input  wire logic               rx_src_long,
    input  wire logic [SADDR_W-1:0] rx_src_short,
    input  wire logic [LADDR_W-1:0] rx_src_long_addr,
    input  wire logic               rx_clash_cmd,
    input  wire logic               rx_realign_cmd,
    input  wire logic               rx_from_parent,
    input  wire logic [ID_W-1:0]    rx_rl_id,
    input  wire logic [CHAN_W-1:0]  rx_rl_chan,
    input  wire logic [SEC_W-1:0]   rx_rl_sec,
    input  wire logic               rx_ack,
    input  wire logic               ack_timeout,
    // transmit engine
    input  wire logic               beacon_due,
    input  wire logic               tx_done,
    input  wire logic               tx_busy_fail,
    output logic                    tx_beacon,
    output logic                    tx_frame_pending,
    output logic                    tx_clash_cmd,
    output logic                    tx_ack_req,
    output logic                    tx_ack,
    output logic                    tx_realign_cmd,
    output logic                    tx_unslotted,
    output logic      [ID_W-1:0]    tx_rl_id,
    output logic      [CHAN_W-1:0]  tx_rl_chan,
    output logic                    beacon_enable,
    // upper layer indications
    output logic                    sync_loss_notice,
    output logic      [1:0]         loss_cause,
    output logic      [1:0]         start_network_cnf,
    output logic                    irq
);
    typedef enum logic [2:0] {
        RL_IDLE     = 3'b000,
        RL_WAIT_BCN = 3'b001,
        RL_BCN_TX   = 3'b010,
        RL_CMD_TX   = 3'b011,
        RL_WAIT_APP = 3'b100,
        RL_WAIT_NEXT = 3'b101
    } nicr_rl_e;

    typedef enum logic [1:0] {
        CL_IDLE = 2'b00,
        CL_SEND = 2'b01,
        CL_WAIT = 2'b10
    } nicr_cl_e;

    typedef struct packed {
        logic [31:0]         ctrl;
        logic [ID_W-1:0]     pshort;
        logic [LADDR_W-1:0]  plong;
        logic [31:0]         req;
        logic [ST_W-1:0]     status;
        logic [ST_W-1:0]     mask;
        logic [31:0]         notice;
        nicr_rl_e            rl;
        nicr_cl_e            cl;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                tx_beacon;
        logic                tx_fp;
        logic                tx_clash;
        logic                tx_ack;
        logic                tx_rl;
        logic                bcn_en;
        logic                notice_p;
        logic [1:0]          cause;
        logic [1:0]          cnf;
        logic                irq;
        logic                apply;
    } nicr_s;

    nicr_s s_q, s_d;

    logic [ID_W-1:0] cur_id;
    logic [31:0]     cur_word;

    // write-one-to-clear with set winning
    function automatic logic [ST_W-1:0] w1c(input logic [ST_W-1:0] cur,
                                            input logic [ST_W-1:0] clr,
                                            input logic [ST_W-1:0] set);
        w1c = (cur & ~clr) | set;
    endfunction

    logic            is_root;
    logic            joined;
    logic            clash_en;
    logic            beaconing;
    logic            bcn_match;
    logic            foreign;
    logic            root_clash;
    logic            dev_clash;
    logic            acc;
    logic            wr;
    logic            rd_ok;
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;
    logic [31:0]     rd;

    always_comb begin
        is_root   = s_q.ctrl[CTRL_IS_ROOT];
        joined    = s_q.ctrl[CTRL_JOINED];
        clash_en  = s_q.ctrl[CTRL_CLASH_EN];
        beaconing = s_q.ctrl[CTRL_BEACONING] && s_q.bcn_en;
        bcn_match = rx_beacon && rx_coord_bit && (rx_net_id == cur_id);
        foreign   = rx_src_long ? (rx_src_long_addr != s_q.plong)
                                : (rx_src_short != s_q.pshort);
        root_clash = is_root && (bcn_match || rx_clash_cmd);
        dev_clash  = !is_root && joined && clash_en && bcn_match && foreign;
        acc = psel && penable && !s_q.pready;
        wr  = acc && pwrite;
        st_set = '0;
        st_clr = '0;
        rd = '0;
        rd_ok = 1'b1;

        s_d = s_q;
        s_d.pready   = 1'b0;
        s_d.pslverr  = 1'b0;
        s_d.tx_beacon = 1'b0;
        s_d.tx_clash = 1'b0;
        s_d.tx_ack   = 1'b0;
        s_d.tx_rl    = 1'b0;
        s_d.notice_p = 1'b0;
        s_d.cnf      = CNF_NONE;
        s_d.apply    = 1'b0;

        // apb register access, answered one cycle after the access phase starts
        case (paddr)
            OFS_CTRL:    rd = s_q.ctrl;
            OFS_NET_ID:  rd = {16'h0000, cur_id};
            OFS_PSHORT:  rd = {16'h0000, s_q.pshort};
            OFS_PLONG_L: rd = s_q.plong[31:0];
            OFS_PLONG_H: rd = s_q.plong[63:32];
            OFS_REQ:     rd = {1'b0, s_q.req[30:0]};
            OFS_CUR:     rd = cur_word;
            OFS_STATUS:  rd = {28'h0000000, s_q.status};
            OFS_MASK:    rd = {28'h0000000, s_q.mask};
            OFS_NOTICE:  rd = s_q.notice;
            default:     rd_ok = 1'b0;
        endcase
        if (acc) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = !rd_ok;
            s_d.prdata  = pwrite ? 32'h0000_0000 : rd;
        end
        if (wr) begin
            case (paddr)
                OFS_CTRL:    s_d.ctrl = pwdata;
                OFS_PSHORT:  s_d.pshort = pwdata[SADDR_W-1:0];
                OFS_PLONG_L: s_d.plong[31:0] = pwdata;
                OFS_PLONG_H: s_d.plong[63:32] = pwdata;
                OFS_REQ: begin
                    if (pwdata[REQ_GO] && s_q.rl != RL_IDLE) begin
                        st_set[ST_REFUSED] = 1'b1;
                    end else if (pwdata[REQ_GO]) begin
                        s_d.req = pwdata;
                        s_d.rl = beaconing ? RL_WAIT_BCN : RL_CMD_TX;
                    end else begin
                        s_d.req = pwdata;
                    end
                end
                OFS_STATUS:  st_clr = pwdata[ST_W-1:0];
                OFS_MASK:    s_d.mask = pwdata[ST_W-1:0];
                default:     ;
            endcase
        end

        // conflict handling
        if (rx_clash_cmd && is_root) begin
            s_d.tx_ack = 1'b1;
        end
        if (root_clash) begin
            s_d.notice_p = 1'b1;
            s_d.cause = CAUSE_CLASH;
        end
        case (s_q.cl)
            CL_IDLE: begin
                if (dev_clash) begin
                    s_d.tx_clash = 1'b1;
                    s_d.cl = CL_SEND;
                end
            end
            CL_SEND: begin
                if (tx_done) begin
                    s_d.cl = CL_WAIT;
                end else if (tx_busy_fail) begin
                    s_d.cl = CL_IDLE;
                end
            end
            CL_WAIT: begin
                if (rx_ack) begin
                    s_d.notice_p = 1'b1;
                    s_d.cause = CAUSE_CLASH;
                    s_d.cl = CL_IDLE;
                end else if (ack_timeout) begin
                    s_d.cl = CL_IDLE;
                end
            end
            default: s_d.cl = CL_IDLE;
        endcase

        // realignment from our own coordinator
        if (rx_realign_cmd && rx_from_parent && !is_root) begin
            s_d.notice_p = 1'b1;
            s_d.cause = CAUSE_REALIGN;
            s_d.notice = {5'h00, rx_rl_chan, rx_rl_sec, rx_rl_id};
        end

        // coordinator realignment sequence
        case (s_q.rl)
            RL_IDLE: ;
            RL_WAIT_BCN: begin
                if (beacon_due) begin
                    s_d.tx_beacon = 1'b1;
                    s_d.tx_fp = 1'b1;
                    s_d.rl = RL_BCN_TX;
                end
            end
            RL_BCN_TX: begin
                if (tx_done) begin
                    s_d.tx_fp = 1'b0;
                    s_d.rl = RL_CMD_TX;
                end
            end
            RL_CMD_TX: begin
                if (!s_q.tx_rl && !s_q.tx_beacon) begin
                    s_d.tx_rl = 1'b1;
                    s_d.rl = RL_WAIT_APP;
                end
            end
            RL_WAIT_APP: begin
                if (tx_busy_fail) begin
                    s_d.cnf = CNF_BUSY;
                    st_set[ST_CNF_BUSY] = 1'b1;
                    s_d.rl = RL_IDLE;
                end else if (tx_done && beaconing) begin
                    // while beaconing the new parameters wait for the next beacon slot
                    s_d.rl = RL_WAIT_NEXT;
                end else if (tx_done) begin
                    s_d.apply = 1'b1;
                    s_d.cnf = CNF_SUCCESS;
                    st_set[ST_CNF_OK] = 1'b1;
                    s_d.rl = RL_IDLE;
                end
            end
            RL_WAIT_NEXT: begin
                if (beacon_due) begin
                    s_d.apply = 1'b1;
                    s_d.cnf = CNF_SUCCESS;
                    st_set[ST_CNF_OK] = 1'b1;
                    s_d.rl = RL_IDLE;
                end
            end
            default: s_d.rl = RL_IDLE;
        endcase

        if (s_d.notice_p) begin
            st_set[ST_NOTICE] = 1'b1;
            s_d.bcn_en = 1'b0;
        end else if (wr && paddr == OFS_CTRL && pwdata[CTRL_BEACONING]) begin
            s_d.bcn_en = 1'b1;
        end
        s_d.status = w1c(s_q.status, st_clr, st_set);
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    nicr_param_store u_store (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (wr && paddr == OFS_NET_ID),
        .load_id  (pwdata[ID_W-1:0]),
        .apply    (s_q.apply),
        .new_id   (s_q.req[ID_W-1:0]),
        .new_chan (s_q.req[REQ_CHAN_LSB +: CHAN_W]),
        .new_bi   (s_q.req[REQ_BI_LSB +: EXP_W]),
        .new_ap   (s_q.req[REQ_AP_LSB +: EXP_W]),
        .cur_id   (cur_id),
        .cur_word (cur_word)
    );

    assign prdata           = s_q.prdata;
    assign pready           = s_q.pready;
    assign pslverr          = s_q.pslverr;
    assign tx_beacon        = s_q.tx_beacon;
    assign tx_frame_pending = s_q.tx_fp;
    assign tx_clash_cmd     = s_q.tx_clash;
    assign tx_ack_req       = s_q.tx_clash;
    assign tx_ack           = s_q.tx_ack;
    assign tx_realign_cmd   = s_q.tx_rl;
    assign tx_unslotted     = s_q.tx_rl;
    assign tx_rl_id         = s_q.req[ID_W-1:0];
    assign tx_rl_chan       = s_q.req[REQ_CHAN_LSB +: CHAN_W];
    assign beacon_enable    = s_q.bcn_en;
    assign sync_loss_notice = s_q.notice_p;
    assign loss_cause       = s_q.cause;
    assign start_network_cnf = s_q.cnf;
    assign irq              = s_q.irq;
endmodule
`default_nettype wire

// [tb/nicr_top_asserts.sv]
// checker for the clash and realignment control block
// bound to nicr_top, sees its ports only, one clock domain
`timescale 1ns/1ns
`default_nettype none
module nicr_top_chk
    import nicr_pkg::*;
(
    // clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // transmit side
    input wire logic       tx_done,
    input wire logic       tx_busy_fail,
    input wire logic       tx_beacon,
    input wire logic       tx_frame_pending,
    input wire logic       tx_clash_cmd,
    input wire logic       tx_ack_req,
    input wire logic       tx_realign_cmd,
    input wire logic       tx_unslotted,
    input wire logic       beacon_enable,
    // receive side and indications
    input wire logic       rx_realign_cmd,
    input wire logic       rx_from_parent,
    input wire logic       sync_loss_notice,
    input wire logic [1:0] loss_cause,
    input wire logic [1:0] start_network_cnf
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ack_req; tx_clash_cmd |-> tx_ack_req; endproperty
    a_ack_req: assert property (p_ack_req) else $error("notify without ack request");
    property p_unsl; tx_realign_cmd |-> tx_unslotted; endproperty
    a_unsl: assert property (p_unsl) else $error("realign not unslotted");
    property p_after_bcn; tx_frame_pending && tx_done |-> ##[1:2] tx_realign_cmd; endproperty
    a_after_bcn: assert property (p_after_bcn) else $error("no command after beacon");
    property p_busy; start_network_cnf == CNF_BUSY |-> $past(tx_busy_fail); endproperty
    a_busy: assert property (p_busy) else $error("busy confirm without failure");
    property p_stop; sync_loss_notice |-> ##[0:1] !beacon_enable; endproperty
    a_stop: assert property (p_stop) else $error("beacons kept after notice");
    property p_rl_note;
        rx_realign_cmd && rx_from_parent |-> ##[1:2] sync_loss_notice && loss_cause == CAUSE_REALIGN;
    endproperty
    a_rl_note: assert property (p_rl_note) else $error("no realign notice");
    property p_cnf; start_network_cnf != CNF_NONE |=> start_network_cnf == CNF_NONE; endproperty
    a_cnf: assert property (p_cnf) else $error("confirm longer than a pulse");
    property p_fp; $rose(tx_frame_pending) |-> tx_beacon; endproperty
    a_fp: assert property (p_fp) else $error("frame pending without beacon");
    c_rl: cover property (tx_realign_cmd);
    c_clash: cover property (sync_loss_notice && loss_cause == CAUSE_CLASH);
    c_busy: cover property (start_network_cnf == CNF_BUSY);
endmodule
bind nicr_top nicr_top_chk nicr_top_chk_inst (.*);
`default_nettype wire

// [tb/nicr_peer_model.sv]
// peer mac and transmit engine: completes frames after dly cycles
// busy_mode fails channel access, ack_mode picks ack or timeout
`timescale 1ns/1ns
`default_nettype none
module nicr_peer_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // frames from the block and behaviour controls
    input  wire logic       tx_beacon,
    input  wire logic       tx_clash_cmd,
    input  wire logic       tx_realign_cmd,
    input  wire logic [3:0] dly,
    input  wire logic       busy_mode,
    input  wire logic       ack_mode,
    // answers
    output logic            tx_done,
    output logic            tx_busy_fail,
    output logic            rx_ack,
    output logic            ack_timeout
);
    logic [3:0] cnt;
    logic       clash;
    logic       ackw;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {cnt, clash, ackw, tx_done, tx_busy_fail, rx_ack, ack_timeout} <= '0;
        end else begin
            tx_done <= cnt == 4'h1 && !busy_mode;
            tx_busy_fail <= cnt == 4'h1 && busy_mode;
            ackw <= cnt == 4'h1 && !busy_mode && clash;
            rx_ack <= ackw && ack_mode;
            ack_timeout <= ackw && !ack_mode;
            if (tx_beacon || tx_clash_cmd || tx_realign_cmd) begin
                cnt <= dly;
                clash <= tx_clash_cmd;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/test_network_id_conflict_realign.sv]
// bench for the clash and realignment control block
// apb master tasks, frame strobes, peer model closes transmissions
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_network_id_conflict_realign
    import nicr_pkg::*;
;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rdat, rl_seen;
    logic               rx_beacon, rx_coord_bit, rx_src_long, rx_clash_cmd, rx_realign_cmd;
    logic               rx_from_parent, rx_ack, ack_timeout, beacon_due, tx_done, tx_busy_fail;
    logic               tx_beacon, tx_frame_pending, tx_clash_cmd, tx_ack_req, tx_ack;
    logic               tx_realign_cmd, tx_unslotted, beacon_enable, sync_loss_notice;
    logic               busy_mode, ack_mode;
    logic [ID_W-1:0]    rx_net_id, rx_rl_id, tx_rl_id;
    logic [SADDR_W-1:0] rx_src_short;
    logic [LADDR_W-1:0] rx_src_long_addr;
    logic [CHAN_W-1:0]  rx_rl_chan, tx_rl_chan;
    logic [SEC_W-1:0]   rx_rl_sec;
    logic [1:0]         loss_cause, start_network_cnf;
    logic [3:0]         dly;
    int                 num_errors, checked, n_cn, n_rn, n_ctx, n_ack, n_rl, n_ok, n_bsy, n_fp;
    nicr_top nicr_top_inst (.*);
    nicr_peer_model nicr_peer_model_inst (.pclk(pclk), .presetn(presetn), .dly(dly),
        .tx_beacon(tx_beacon), .tx_clash_cmd(tx_clash_cmd), .tx_realign_cmd(tx_realign_cmd),
        .busy_mode(busy_mode), .ack_mode(ack_mode), .tx_done(tx_done),
        .tx_busy_fail(tx_busy_fail), .rx_ack(rx_ack), .ack_timeout(ack_timeout));
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    // event tallies, sampled at each rising edge
    always @(posedge pclk) begin
        n_cn += int'(sync_loss_notice === 1'b1 && loss_cause === CAUSE_CLASH);
        n_rn += int'(sync_loss_notice === 1'b1 && loss_cause === CAUSE_REALIGN);
        n_ctx += int'(tx_clash_cmd === 1'b1);
        n_ack += int'(tx_ack === 1'b1);
        n_rl += int'(tx_realign_cmd === 1'b1);
        n_ok += int'(start_network_cnf === CNF_SUCCESS);
        n_bsy += int'(start_network_cnf === CNF_BUSY);
        n_fp += int'(tx_beacon === 1'b1 && tx_frame_pending === 1'b1);
        if (tx_realign_cmd === 1'b1) rl_seen = {tx_rl_chan, tx_rl_id};
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // k: 0 plain beacon, 1 parent beacon, 2 foreign beacon, 3 notify cmd,
    // 4 realign from parent, 5 realign from other, 6 beacon slot, 7 idle
    task automatic frame(input int k, input logic [15:0] v);
        {rx_coord_bit, rx_src_long} <= {k != 0, k == 2};
        rx_net_id <= v;
        rx_rl_id <= v;
        rx_from_parent <= k == 4;
        {rx_beacon, rx_clash_cmd, rx_realign_cmd, beacon_due} <= {k < 3, k == 3, k == 4 || k == 5, k == 6};
        @(posedge pclk);
        {rx_beacon, rx_clash_cmd, rx_realign_cmd, beacon_due} <= 4'h0;
        rx_net_id <= ~v;
        rx_rl_id <= ~v;
        repeat (16) @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        finish_test();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rx_beacon, rx_coord_bit, rx_src_long} = '0;
        {rx_clash_cmd, rx_realign_cmd, rx_from_parent, beacon_due, busy_mode, ack_mode} = 6'h01;
        {rx_net_id, rx_rl_id, rx_src_short, rx_src_long_addr} = {48'h1, 64'h1};
        {rx_rl_chan, rx_rl_sec, dly} = {3'h3, 8'ha5, 4'h1};
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CTRL, '0);
        `CHK("ctrl rst", CTRL_RST, rdat)
        apb(1'b0, OFS_CUR, '0);
        `CHK("cur rst", CUR_RST, rdat)
        apb(1'b0, 8'h3c, '0);
        `CHK("unmapped", 1'b1, rerr)
        apb(1'b1, OFS_MASK, 32'h0000_000f);
        apb(1'b1, OFS_NET_ID, 32'h0000_1234);
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        frame(0, 16'h1234);
        frame(1, 16'h1235);
        frame(1, 16'h1234);
        `CHK("root clash", 1, n_cn)
        `CHK("irq up", 1'b1, irq)
        apb(1'b1, OFS_STATUS, 32'h0000_000f);
        apb(1'b0, OFS_STATUS, '0);
        `CHK("irq clear", 1'b0, irq)
        frame(3, 16'h1234);
        `CHK("ack sent", 1, n_ack)
        `CHK("notify clash", 2, n_cn)
        apb(1'b1, OFS_PSHORT, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0006);
        frame(1, 16'h1234);
        `CHK("parent bcn", 0, n_ctx)
        frame(2, 16'h1234);
        `CHK("notify out", 1, n_ctx)
        `CHK("acked note", 3, n_cn)
        ack_mode <= 1'b0;
        frame(2, 16'h1234);
        `CHK("unacked", 3, n_cn)
        apb(1'b1, OFS_MASK, '0);
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        `CHK("irq masked", 1'b0, irq)
        frame(2, 16'h1234);
        `CHK("clash off", 2, n_ctx)
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        apb(1'b1, OFS_REQ, 32'h83f5_abcd);
        frame(7, '0);
        `CHK("rl sent", 1, n_rl)
        `CHK("rl id chan", 32'h5_abcd, rl_seen)
        `CHK("cnf ok", 1, n_ok)
        apb(1'b0, OFS_CUR, '0);
        `CHK("nonbeacon", 32'h0ff5_abcd, rdat)
        apb(1'b1, OFS_STATUS, 32'h0000_000f);
        {busy_mode, dly} <= 5'h14;
        apb(1'b1, OFS_REQ, 32'h8312_0042);
        apb(1'b1, OFS_REQ, 32'h8312_0042);
        frame(7, '0);
        `CHK("cnf busy", 1, n_bsy)
        apb(1'b0, OFS_STATUS, '0);
        `CHK("refused", 2'b11, rdat[3:2])
        apb(1'b0, OFS_CUR, '0);
        `CHK("kept", 32'h0ff5_abcd, rdat)
        {busy_mode, dly} <= 5'h02;
        apb(1'b1, OFS_CTRL, 32'h0000_0009);
        apb(1'b1, OFS_REQ, 32'h8325_0077);
        frame(7, '0);
        `CHK("wait bcn", 2, n_rl)
        frame(6, '0);
        `CHK("pending bcn", 1, n_fp)
        `CHK("rl after", 3, n_rl)
        `CHK("no early", 1, n_ok)
        frame(6, '0);
        `CHK("cnf at bcn", 2, n_ok)
        apb(1'b0, OFS_CUR, '0);
        `CHK("bcn params", 32'h0325_0077, rdat)
        apb(1'b1, OFS_CTRL, 32'h0000_000a);
        `CHK("bcn on", 1'b1, beacon_enable)
        frame(5, 16'h5555);
        frame(4, 16'h5555);
        `CHK("rl note", 1, n_rn)
        `CHK("bcn stop", 1'b0, beacon_enable)
        apb(1'b0, OFS_NOTICE, '0);
        `CHK("note flds", 32'h03a5_5555, rdat)
        finish_test();
    end
endmodule
`default_nettype wire
